// [core/ntp_reply_builder.sv]
/*
  Server reply builder for time-protocol requests: takes the request
  message bytes, checks optional keyed-digest credentials, then emits
  the filled reply, with a fresh digest when the request's digest checked out.
  Assumes the UDP stack strips headers, the digest engine sits outside
  behind the hash port, and time inputs are on core_clk.
*/
// Function
// R1 - Timestamps are 64-bit seconds.fraction since 1900
// R2 - Leap field codes none, 61s, 59s, alarm
// R3 - Alarm after power-on until first acquisition
// R4 - Timing parameter change raises alarm again
// R5 - Version copied from request
// R6 - Mode always server, clock never client-steered
// R7 - Stratum is one
// R8 - Poll copied from request
// R9 - Precision is minus nineteen
// R10 - Root distance always zero
// R11 - Reference id names selected source
// R12 - Reference stamp frozen while signal lost
// R13 - Receive stamp is request arrival time
// R14 - Transmit stamp is reply departure time
// R15 - Client fills originate stamp
// R16 - Digest is keyed hash, key first
// R17 - Four stored identifier and key pairs
// R18 - Valid credentials give signed reply
// R19 - Failed check gives unsigned reply
// R20 - Auth-only mode drops unauthenticated requests
// R21 - Signed reply carries full 16-byte digest
// R22 - Message area starts right after UDP header
// R23 - Digest covers key then reply fields
// R24 - Stamp receive early, transmit late
`timescale 1ns/1ps
module ntp_reply_builder
  import ntp_reply_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Time base and timing source
  input  wire logic [63:0] local_time,
  input  wire logic [1:0]  leap_in,
  input  wire logic        timing_valid,
  input  wire logic        time_acquired,
  input  wire logic        param_change,
  input  wire logic        source_sat,
  // Configuration
  input  wire logic        auth_en,
  input  wire logic        auth_only,
  input  wire logic        key_load_valid,
  input  wire logic [1:0]  key_load_index,
  input  wire logic [31:0] key_load_id,
  input  wire logic [63:0] key_load_key,
  // Request bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             rx_ready,
  // Reply bytes
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  // Digest engine
  output logic             hash_valid,
  output logic [7:0]       hash_data,
  output logic             hash_last,
  input  wire logic        hash_ready,
  input  wire logic        hash_done,
  input  wire logic [127:0] hash_digest,
  // Status
  output logic             alarm,
  output logic             drop_pulse,
  output logic             fail_pulse
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_DECIDE, ST_HASH, ST_HWAIT, ST_SEND
  } state_e;

  state_e         state;
  logic [7:0]     req [AUTH_LEN];
  logic [6:0]     rx_cnt;
  logic [6:0]     cnt;
  logic [6:0]     tx_idx;
  logic [6:0]     tx_len;
  logic           signing;
  logic           signed_reply;
  logic [63:0]    ref_ts;
  logic [63:0]    ref_snap;
  logic [63:0]    rx_ts;
  logic [63:0]    tx_ts;
  logic [127:0]   sign_digest;
  logic [383:0]   reply_vec;
  logic [543:0]   frame_vec;
  logic [31:0]    req_keyid;
  logic [63:0]    req_orig;
  logic [127:0]   req_digest;
  logic           key_hit;
  logic [63:0]    key;
  logic [7:0]     hash_byte;
  logic           rx_take;

  function automatic logic [63:0] get64(input int base);
    logic [63:0] v;
    v = 64'h0;
    for (int i = 0; i < 8; i++) begin
      v = {v[55:0], req[base + i]};
    end
    return v;
  endfunction

  key_table #(
    .ENTRIES    (NUM_KEYS)
  ) u_keys (
    .core_clk   (core_clk),
    .rst        (rst),
    .load_valid (key_load_valid),
    .load_index (key_load_index),
    .load_id    (key_load_id),
    .load_key   (key_load_key),
    .look_id    (req_keyid),
    .look_hit   (key_hit),
    .look_key   (key)
  );

  // Byte accepted from the request stream
  assign rx_take    = rx_valid && rx_ready;

  // Request fields and reply image; process reruns on any request byte
  always_comb begin
    req_keyid  = 32'(get64(KEYID_POS - 4)); // see R22
    req_orig   = get64(XMIT_POS);
    req_digest = {get64(DIGEST_POS), get64(DIGEST_POS + 8)};
    reply_vec = {alarm ? LEAP_ALARM : leap_in, // see R2
                 req[0][VER_HI:VER_LO],        // see R5
                 MODE_SERVER,                  // see R6
                 STRATUM_PRIME,                // see R7
                 req[2],                       // see R8
                 PRECISION_EXP,                // see R9
                 ROOT_DIST,                    // see R10
                 ROOT_DISP,
                 source_sat ? REFID_SAT : REFID_FREE, // see R11
                 ref_snap, req_orig, rx_ts, tx_ts}; // see R1 see R12
    frame_vec = {reply_vec, req_keyid, sign_digest}; // see R21
  end

  // Hash input: secret key first, then the request being checked or the reply being signed
  always_comb begin
    if (cnt < 7'(KEY_BYTES)) begin // see R16
      hash_byte = key[8 * (KEY_BYTES - 1 - int'(cnt)) +: 8];
    end else if (signing) begin // see R23
      hash_byte = reply_vec[8 * (HASH_LEN - 1 - int'(cnt)) +: 8];
    end else begin
      hash_byte = req[int'(cnt) - KEY_BYTES];
    end
  end

  // Alarm from power-on and on parameter change until acquisition
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarm <= 1'b1; // see R3
    end else if (param_change) begin
      alarm <= 1'b1; // see R4
    end else if (time_acquired) begin
      alarm <= 1'b0; // see R3
    end
  end

  // Reference stamp follows time only while the signal is valid
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_ts <= 64'h0;
    end else if (timing_valid) begin
      ref_ts <= local_time; // see R12
    end
  end

  // Request capture and arrival stamp
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_cnt <= 7'h0;
      rx_ts  <= 64'h0;
    end else if (rx_take) begin
      if (state == ST_IDLE) begin
        rx_ts  <= local_time; // see R13 see R24
        rx_cnt <= 7'h1;
      end else if (rx_cnt != 7'h7F) begin
        rx_cnt <= rx_cnt + 7'h1;
      end
    end
  end

  for (genvar b = 0; b < AUTH_LEN; b++) begin : g_req
    always_ff @(posedge core_clk) begin
      if (rst) begin
        req[b] <= 8'h00;
      end else if (rx_take && (state == ST_IDLE ? b == 0
                   : state == ST_RECV && rx_cnt == 7'(b))) begin
        req[b] <= rx_data;
      end
    end
  end

  // Sequencer: receive, decide, hash, send
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state        <= ST_IDLE;
      rx_ready     <= 1'b0;
      cnt          <= 7'h0;
      signing      <= 1'b0;
      signed_reply <= 1'b0;
      tx_len       <= 7'(NTP_LEN);
      tx_ts        <= 64'h0;
      sign_digest  <= 128'h0;
      drop_pulse   <= 1'b0;
      fail_pulse   <= 1'b0;
      hash_valid   <= 1'b0;
      hash_data    <= 8'h00;
      hash_last    <= 1'b0;
    end else begin
      drop_pulse <= 1'b0;
      fail_pulse <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          rx_ready <= 1'b1;
          if (rx_take) begin
            state <= rx_last ? ST_DECIDE : ST_RECV;
            rx_ready <= !rx_last;
          end
        end
        ST_RECV: begin
          if (rx_take && rx_last) begin
            state    <= ST_DECIDE;
            rx_ready <= 1'b0;
          end
        end
        ST_DECIDE: begin
          cnt          <= 7'h0;
          signing      <= 1'b0;
          signed_reply <= 1'b0;
          tx_len       <= 7'(NTP_LEN);
          ref_snap     <= ref_ts; // see R12
          if (rx_cnt < 7'(NTP_LEN)) begin
            state <= ST_IDLE;
            drop_pulse <= 1'b1;
          end else if (!auth_en) begin
            state <= ST_SEND;
            tx_ts <= local_time; // see R14 see R24
          end else if (rx_cnt == 7'(AUTH_LEN) && key_hit) begin
            state <= ST_HASH;
          end else if (auth_only) begin
            state <= ST_IDLE; // see R20
            drop_pulse <= 1'b1;
            fail_pulse <= 1'b1;
          end else begin
            state <= ST_SEND; // see R19
            fail_pulse <= 1'b1;
            tx_ts <= local_time;
          end
        end
        ST_HASH: begin
          if (!hash_valid || hash_ready) begin
            if (cnt < 7'(HASH_LEN)) begin
              hash_valid <= 1'b1;
              hash_data  <= hash_byte;
              hash_last  <= cnt == 7'(HASH_LEN - 1);
              cnt        <= cnt + 7'h1;
            end else begin
              hash_valid <= 1'b0;
              hash_last  <= 1'b0;
              state      <= ST_HWAIT;
            end
          end
        end
        ST_HWAIT: begin
          if (hash_done) begin
            cnt <= 7'h0;
            if (signing) begin
              sign_digest  <= hash_digest; // see R18
              signed_reply <= 1'b1;
              tx_len       <= 7'(AUTH_LEN); // see R21
              state        <= ST_SEND;
            end else if (hash_digest == req_digest) begin
              signing <= 1'b1;
              tx_ts   <= local_time; // see R14 see R24
              state   <= ST_HASH;
            end else if (auth_only) begin
              state <= ST_IDLE; // see R20
              drop_pulse <= 1'b1;
              fail_pulse <= 1'b1;
            end else begin
              state <= ST_SEND; // see R19
              fail_pulse <= 1'b1;
              tx_ts <= local_time;
            end
          end
        end
        ST_SEND: begin
          if (tx_valid && tx_ready && tx_last) begin
            state    <= ST_IDLE;
            rx_ready <= 1'b1;
          end
        end
      endcase
    end
  end

  // Reply output register; stalls on tx_ready
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_idx   <= 7'h0;
    end else if (!tx_valid || tx_ready) begin
      if (state == ST_SEND && !(tx_valid && tx_last)
          && (!tx_valid || tx_idx < tx_len - 7'h1)) begin
        tx_valid <= 1'b1;
        tx_idx   <= tx_valid ? tx_idx + 7'h1 : 7'h0;
        tx_data  <= frame_vec[8 * (AUTH_LEN - 1
                     - int'(tx_valid ? tx_idx + 7'h1 : 7'h0)) +: 8];
        tx_last  <= (tx_valid ? tx_idx + 7'h1 : 7'h0) == tx_len - 7'h1;
      end else begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
    end
  end

  // Checks on leap, fixed fields, stamps and authentication
  a_alarm_at_reset: assert property (@(posedge core_clk) // see R3
    $fell(rst) |-> alarm)
    else $error("alarm not set after reset");
  a_alarm_on_change: assert property (@(posedge core_clk) disable iff (rst)
    param_change |=> alarm ##0 reply_vec[383:382] == LEAP_ALARM) // see R4
    else $error("parameter change did not raise alarm");
  a_alarm_clears: assert property (@(posedge core_clk) disable iff (rst)
    time_acquired && !param_change |=> !alarm) // see R3
    else $error("alarm stuck after acquisition");
  a_mode_server: assert property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_idx == 7'h0 |-> tx_data[MODE_HI:0] == MODE_SERVER) // see R6
    else $error("mode field not server");
  a_stratum_one: assert property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_idx == 7'h1 |-> tx_data == STRATUM_PRIME) // see R7
    else $error("stratum not one");
  a_precision_val: assert property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_idx == 7'h3 |-> tx_data == PRECISION_EXP) // see R9
    else $error("precision wrong");
  a_ref_frozen: assert property (@(posedge core_clk) disable iff (rst)
    !timing_valid |=> $stable(ref_ts)) // see R12
    else $error("reference stamp moved without signal");
  a_rx_stamp: assert property (@(posedge core_clk) disable iff (rst)
    rx_take && state == ST_IDLE |=> rx_ts == $past(local_time)) // see R13
    else $error("receive stamp not taken at first byte");
  a_drop_auth: assert property (@(posedge core_clk) disable iff (rst)
    drop_pulse && rx_cnt >= 7'(NTP_LEN) |-> $past(auth_only)) // see R20
    else $error("drop without authentication-only");
  a_signed_len: assert property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_last |-> tx_idx == tx_len - 7'h1
    ##0 (tx_len == 7'(AUTH_LEN)) == signed_reply) // see R21
    else $error("reply length does not match signing");

  c_plain_reply: cover property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_last && !signed_reply);
  c_signed_reply: cover property (@(posedge core_clk) disable iff (rst)
    tx_valid && tx_last && signed_reply);
  c_dropped: cover property (@(posedge core_clk) disable iff (rst)
    drop_pulse && auth_only);
  c_fail_plain: cover property (@(posedge core_clk) disable iff (rst)
    fail_pulse && !auth_only);
endmodule

// [core/ntp_reply_pkg.sv]
/*
  Shared constants for the time-protocol reply builder: message layout,
  fixed field values and authentication sizes.
  Assumes byte streams carry the message area starting right after the
  UDP header, most significant byte of each field first.
*/
package ntp_reply_pkg;
  // Message layout in bytes
  localparam int NTP_LEN    = 48;
  localparam int KEYID_POS  = 48;
  localparam int DIGEST_POS = 52;
  localparam int AUTH_LEN   = 68;
  localparam int XMIT_POS   = 40;
  localparam int KEY_BYTES  = 8;
  localparam int HASH_LEN   = KEY_BYTES + NTP_LEN;
  localparam int NUM_KEYS   = 4;
  localparam int TS_W       = 64;
  localparam int DIGEST_W   = 128;
  // Field codes
  localparam logic [1:0] LEAP_ALARM     = 2'h3;
  localparam logic [2:0] MODE_SERVER    = 3'h4;
  localparam logic [7:0] STRATUM_PRIME  = 8'h01;
  localparam logic [7:0] PRECISION_EXP  = 8'hED;
  localparam logic [31:0] ROOT_DIST     = 32'h0000_0000;
  localparam logic [31:0] ROOT_DISP     = 32'h0000_0000;
  localparam logic [31:0] REFID_SAT     = 32'h4750_5300;
  localparam logic [31:0] REFID_FREE    = 32'h4652_4545;
  // Bit positions in the first message byte
  localparam int LEAP_HI = 7;
  localparam int VER_HI  = 5;
  localparam int VER_LO  = 3;
  localparam int MODE_HI = 2;
endpackage

// [core/key_table.sv]
/*
  Key identifier and secret key store with a parallel lookup.
  Assumes the non-volatile copy is loaded into it after reset over the
  load port; identifier zero never matches.
*/
`timescale 1ns/1ps
module key_table
  import ntp_reply_pkg::*;
#(
  parameter int ENTRIES = NUM_KEYS
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Loading
  input  wire logic        load_valid,
  input  wire logic [1:0]  load_index,
  input  wire logic [31:0] load_id,
  input  wire logic [63:0] load_key,
  // Lookup
  input  wire logic [31:0] look_id,
  output logic             look_hit,
  output logic [63:0]      look_key
);
  logic [31:0]        ids [ENTRIES];
  logic [63:0]        keys [ENTRIES];
  logic [ENTRIES-1:0] match;

  // One storage slot and comparator per entry
  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    always_ff @(posedge core_clk) begin
      if (rst) begin
        ids[i]  <= 32'h0000_0000;
        keys[i] <= 64'h0;
      end else if (load_valid && load_index == 2'(i)) begin // see R17
        ids[i]  <= load_id;
        keys[i] <= load_key;
      end
    end
    assign match[i] = (look_id != 32'h0) && (ids[i] == look_id);
  end

  // Lowest matching entry wins
  always_comb begin
    look_hit = |match;
    look_key = 64'h0;
    for (int j = ENTRIES - 1; j >= 0; j--) begin
      if (match[j]) begin
        look_key = keys[j];
      end
    end
  end
endmodule

// [test/ntp_client_model.sv]
/*
  Client stand-in for the reply builder: sends request bytes, then
  collects the reply while stalling it now and then.
  Assumes the bench fills req and calls send and recv in turn.
*/
`timescale 1ns/1ps
module ntp_client_model (
  // Clock
  input  wire logic       core_clk,
  // Request stream
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  input  wire logic       rx_ready,
  // Reply stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] req [68];
  logic [7:0] rep [68];
  int         rep_n;
  logic       hung;

  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    hung     = 1'b0;
  end

  // Message byte 0 first, held until taken, data inverted once released
  task automatic send(input int n);
    int k;
    int w;
    k = 0;
    w = 0;
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data  <= req[0];
    rx_last  <= (n == 1);
    while (k < n && w < 300) begin
      @(posedge core_clk);
      w++;
      if (rx_ready) begin
        k++;
        rx_valid <= (k < n);
        rx_data  <= (k < n) ? req[k] : ~req[n-1];
        rx_last  <= (k == n - 1);
      end
    end
    hung |= (w >= 300);
  endtask

  // Collect reply bytes up to the last one, ready low every third cycle
  task automatic recv(input int lim, input logic must);
    int w;
    rep_n = 0;
    w = 0;
    while (w < lim) begin
      @(posedge core_clk);
      w++;
      if (tx_valid && tx_ready && rep_n < 68) begin
        rep[rep_n] = tx_data;
        rep_n++;
        if (tx_last)
          w = lim + 1;
      end
      tx_ready <= (w % 3 != 0);
    end
    hung |= (w == lim) && must;
  endtask
endmodule

// [test/ntp_server_reply_builder_tb.sv]
/*
  Self-checking bench for the reply builder: time base, key load,
  a stalling digest engine stand-in and a client model.
  Assumes the digest engine answers a fixed digest for every stream.
*/
`timescale 1ns/1ps
module ntp_server_reply_builder_tb;
  import ntp_reply_pkg::*;
  localparam logic [127:0] DIG = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  localparam logic [31:0]  KID = 32'h0000_0A0B;
  localparam logic [63:0]  KEY = 64'h6B33_7953_3167_6E38;
  logic        core_clk, rst, timing_valid, time_acquired, param_change;
  logic        source_sat, auth_en, auth_only, key_load_valid;
  logic [63:0] local_time, key_load_key, t_ref, t_rx, t_last, t_b40;
  logic [1:0]  leap_in, key_load_index;
  logic [31:0] key_load_id;
  logic        rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0]  rx_data, tx_data, hash_data;
  logic        hash_valid, hash_last, hash_ready, hash_done;
  logic        alarm, drop_pulse, fail_pulse;
  logic [7:0]  hb [112];
  int          n_mismatch, checks, rxc, txc, hn, hw, n_fail, n_drop;

  ntp_reply_builder dut (
    .core_clk(core_clk), .rst(rst), .local_time(local_time),
    .leap_in(leap_in), .timing_valid(timing_valid),
    .time_acquired(time_acquired), .param_change(param_change),
    .source_sat(source_sat), .auth_en(auth_en), .auth_only(auth_only),
    .key_load_valid(key_load_valid), .key_load_index(key_load_index),
    .key_load_id(key_load_id), .key_load_key(key_load_key),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .hash_valid(hash_valid),
    .hash_data(hash_data), .hash_last(hash_last),
    .hash_ready(hash_ready), .hash_done(hash_done), .hash_digest(DIG),
    .alarm(alarm), .drop_pulse(drop_pulse), .fail_pulse(fail_pulse));

  ntp_client_model cli (
    .core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  // Clock at 200 MHz
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Time base, seconds over fraction, one tick a cycle
  always @(posedge core_clk)
    local_time <= local_time + 64'h1;

  // Digest engine stand-in: stalls every other cycle, done 4 after last
  always @(posedge core_clk) begin
    hash_ready <= ~hash_ready;
    hash_done  <= 1'b0;
    if (hash_valid && hash_ready && hn < 112) begin
      hb[hn] = hash_data;
      hn++;
      if (hash_last)
        hw = 4;
    end
    if (hw > 0) begin
      hw--;
      hash_done <= (hw == 0);
    end
  end

  // Arrival, departure and status pulse monitor
  always @(posedge core_clk) begin
    if (rx_valid && rx_ready) begin
      if (rxc == 0)
        t_rx = local_time;
      if (rx_last)
        t_last = local_time;
      rxc++;
    end
    if (tx_valid && tx_ready) begin
      if (txc == 40)
        t_b40 = local_time;
      txc++;
    end
    n_fail += int'(fail_pulse);
    n_drop += int'(drop_pulse);
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Big-endian 64-bit field of the reply
  function automatic logic [63:0] w64(input int p);
    w64 = 64'h0;
    for (int i = 0; i < 8; i++)
      w64 = {w64[55:0], cli.rep[p+i]};
  endfunction

  // Timing signal lost at the next edge
  task automatic lose();
    @(posedge core_clk);
    t_ref = local_time;
    timing_valid <= 1'b0;
  endtask

  task automatic xfer(input int nq, input int np, input logic [1:0] lk,
                      input int ef);
    int f0;
    int d0;
    f0 = n_fail;
    d0 = n_drop;
    rxc = 0;
    txc = 0;
    hn = 0;
    cli.send(nq);
    cli.recv((np > 0) ? 500 : 150, np > 0);
    if (cli.hung) begin
      n_mismatch++;
      conclude();
    end
    chk(cli.rep_n, np);
    chk(n_drop - d0, np == 0);
    chk(n_fail - f0, ef);
    if (np > 0) begin
      chk(cli.rep[0], {lk, cli.req[0][5:3], 3'h4});
      chk(cli.rep[1], STRATUM_PRIME);
      chk(cli.rep[2], cli.req[2]);
      chk(cli.rep[3], PRECISION_EXP);
      chk(w64(4), 64'h0);
      chk(w64(8), {32'h0, source_sat ? {"GPS", 8'h00} : "FREE"});
      chk(w64(16), t_ref);
      chk(w64(32), t_rx);
      chk({63'h0, w64(40) > t_last && w64(40) < t_b40}, 64'h1);
      if (np == 68)
        chk(32'(w64(44)), KID);
      for (int k = 0; k < 48; k++) begin
        if (k < 8) begin
          chk(cli.rep[24 + k], cli.req[40 + k]);
          if (hn > 0)
            chk(hb[k], KEY[63 - 8 * k -: 8]);
        end
        if (np == 68) begin
          chk(hb[64 + k], cli.rep[k]);
          if (k < 8)
            chk(hb[56 + k], KEY[63 - 8 * k -: 8]);
          if (k < 16)
            chk(cli.rep[52 + k], DIG[127 - 8 * k -: 8]);
        end
      end
    end
  endtask

  // Main sequence
  initial begin
    {rst, timing_valid, hash_ready} = 3'h7;
    {time_acquired, param_change, source_sat, auth_en, auth_only} = 5'h00;
    {key_load_valid, key_load_index, key_load_id, key_load_key} = 99'h0;
    {hash_done, leap_in, hw, hn} = '0;
    {n_mismatch, checks, rxc, txc, n_fail, n_drop} = '0;
    local_time = 64'hE8A1_3C00_FFFF_FF00;
    // Request pattern; bytes 40..47 carry the client departure time
    for (int k = 0; k < 68; k++)
      cli.req[k] = 8'(k * 7 + 3);
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(alarm, 1'b1);
    lose();
    xfer(48, 48, 2'h3, 0);
    time_acquired <= 1'b1;
    @(posedge core_clk);
    time_acquired <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      leap_in    <= 2'(i);
      source_sat <= i[0];
      cli.req[0] = {2'h0, 3'(i + 2), 3'h3};
      cli.req[2] = 8'(250 + i);
      xfer(48, 48, 2'(i), 0);
    end
    // Parameter change in the same cycle as acquisition
    param_change  <= 1'b1;
    time_acquired <= 1'b1;
    @(posedge core_clk);
    {param_change, time_acquired} <= 2'h0;
    @(posedge core_clk);
    chk(alarm, 1'b1);
    xfer(48, 48, 2'h3, 0);
    time_acquired <= 1'b1;
    @(posedge core_clk);
    time_acquired <= 1'b0;
    @(posedge core_clk);
    chk(alarm, 1'b0);
    timing_valid <= 1'b1;
    repeat (6) @(posedge core_clk);
    lose();
    xfer(48, 48, 2'h2, 0);
    xfer(20, 0, 2'h2, 0);
    // Key slot load, then signed traffic
    key_load_valid <= 1'b1;
    key_load_index <= 2'h2;
    key_load_id    <= KID;
    key_load_key   <= KEY;
    @(posedge core_clk);
    key_load_valid <= 1'b0;
    auth_en        <= 1'b1;
    for (int k = 0; k < 4; k++)
      cli.req[48 + k] = KID[31 - 8 * k -: 8];
    for (int k = 0; k < 16; k++)
      cli.req[52 + k] = DIG[127 - 8 * k -: 8];
    xfer(68, 68, 2'h2, 0);
    cli.req[67] = ~cli.req[67];
    xfer(68, 48, 2'h2, 1);
    xfer(48, 48, 2'h2, 1);
    auth_only <= 1'b1;
    xfer(68, 0, 2'h2, 1);
    xfer(48, 0, 2'h2, 1);
    cli.req[67] = ~cli.req[67];
    xfer(68, 68, 2'h2, 0);
    conclude();
  end
endmodule
